// ===== design/aperture_addr.sv
`timescale 1ns/1ps
`default_nettype none

// Joins a 22-bit offset to the graphics base; offset stays inside the 4 MB aperture.
module aperture_addr (
  // Base and offset
  input  wire logic [31:0] graphics_base_address_i,
  input  wire logic [21:0] offset_i,
  // Physical byte address
  output logic      [31:0] addr_o
);

  // Base is 4 MB aligned, so the offset can never leave the aperture
  assign addr_o = {graphics_base_address_i[31:22], offset_i};

endmodule : aperture_addr

`default_nettype wire

// ===== design/display_buffer_offset_registers.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - The frame buffer start field bits 21:0 is a byte offset from the graphics base.
// - Every buffer address is confined to a 4 MB aperture at the graphics base.
// - A nonzero frame start write defers its bits 21:4 to the next frame scan start.
// - The frame start pixel offset bits 3:0 take effect at once on the write.
// - Compressed buffer start is a 16-byte aligned byte offset; low four bits held zero.
// - Cursor start is a byte offset kept four-byte aligned by zero low two bits.
// - The cursor pattern is fetched as one linear block from its start, no stride.
// - Video buffer start is a 16-byte aligned byte offset; low four bits held zero.
module display_buffer_offset_registers (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Display engine side
  input  wire logic [31:0] graphics_base_address_i,
  input  wire logic        frame_start_i,
  output logic      [31:0] frame_buffer_addr_o,
  output logic      [3:0]  pixel_offset_o,
  output logic             frame_update_pending_o,
  output logic      [31:0] compressed_buffer_addr_o,
  output logic      [31:0] cursor_pattern_addr_o,
  output logic      [31:0] video_buffer_addr_o
);

  typedef struct packed {
    logic [21:0] fb;
    logic [21:0] cb;
    logic [21:0] cur;
    logic [21:0] vid;
    logic [31:0] rdata;
  } regs_s;

  regs_s r_q;
  regs_s r_d;

  logic        fb_wr;
  logic [17:0] fb_line;
  logic [3:0]  fb_pix;
  logic [21:0] fb_live;

  function automatic logic [31:0] zext(input logic [21:0] v);
    zext = {10'h000, v};
  endfunction : zext

  assign fb_wr = wr_i && (addr_i == offset_regs_pkg::FB_START_ADDR);

  always_comb begin
    r_d = r_q;
    // Write decode; upper bits dropped on capture
    if (wr_i) begin
      if (addr_i == offset_regs_pkg::FB_START_ADDR) begin
        r_d.fb = wdata_i[21:0];
      end else if (addr_i == offset_regs_pkg::CB_START_ADDR) begin
        r_d.cb = {wdata_i[21:4], 4'h0};
      end else if (addr_i == offset_regs_pkg::CUR_START_ADDR) begin
        r_d.cur = {wdata_i[21:2], 2'h0};
      end else if (addr_i == offset_regs_pkg::VID_START_ADDR) begin
        r_d.vid = {wdata_i[21:4], 4'h0};
      end
    end
    // Read data valid only the cycle after the strobe
    r_d.rdata = 32'h00000000;
    if (rd_i) begin
      if (addr_i == offset_regs_pkg::FB_START_ADDR) begin
        r_d.rdata = zext(r_q.fb);
      end else if (addr_i == offset_regs_pkg::CB_START_ADDR) begin
        r_d.rdata = zext(r_q.cb);
      end else if (addr_i == offset_regs_pkg::CUR_START_ADDR) begin
        r_d.rdata = zext(r_q.cur);
      end else if (addr_i == offset_regs_pkg::GAP_WORD_ADDR) begin
        r_d.rdata = offset_regs_pkg::GAP_WORD_VALUE;
      end else if (addr_i == offset_regs_pkg::VID_START_ADDR) begin
        r_d.rdata = zext(r_q.vid);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign rdata_o = r_q.rdata;

  frame_start_stage u_fb_stage (
    .core_clk_i     (core_clk_i),
    .rst_i          (rst_i),
    .wr_i           (fb_wr),
    .wdata_i        (wdata_i[21:0]),
    .frame_start_i  (frame_start_i),
    .line_addr_o    (fb_line),
    .pixel_offset_o (fb_pix),
    .pending_o      (frame_update_pending_o)
  );

  assign fb_live        = {fb_line, fb_pix};
  assign pixel_offset_o = fb_pix;

  // All addresses stay in the aperture
  aperture_addr u_fb_addr (
    .graphics_base_address_i (graphics_base_address_i),
    .offset_i                (fb_live),
    .addr_o                  (frame_buffer_addr_o)
  );

  aperture_addr u_cb_addr (
    .graphics_base_address_i (graphics_base_address_i),
    .offset_i                (r_q.cb),
    .addr_o                  (compressed_buffer_addr_o)
  );

  // Linear cursor block: start only, no line stride
  aperture_addr u_cur_addr (
    .graphics_base_address_i (graphics_base_address_i),
    .offset_i                (r_q.cur),
    .addr_o                  (cursor_pattern_addr_o)
  );

  aperture_addr u_vid_addr (
    .graphics_base_address_i (graphics_base_address_i),
    .offset_i                (r_q.vid),
    .addr_o                  (video_buffer_addr_o)
  );

endmodule : display_buffer_offset_registers

`default_nettype wire

// ===== design/frame_start_stage.sv
`timescale 1ns/1ps
`default_nettype none

// Holds the line-address part of a nonzero write back until the next frame scan begins; a zero write applies at once.
module frame_start_stage (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Write side
  input  wire logic        wr_i,
  input  wire logic [21:0] wdata_i,
  input  wire logic        frame_start_i,
  // Live values
  output logic      [17:0] line_addr_o,
  output logic      [3:0]  pixel_offset_o,
  output logic             pending_o
);

  typedef struct packed {
    logic [17:0] line_pend;
    logic        pend;
    logic [17:0] line_live;
    logic [3:0]  pix_live;
  } stage_s;

  stage_s st_q;
  stage_s st_d;

  always_comb begin
    st_d = st_q;
    if (frame_start_i && st_q.pend) begin
      st_d.line_live = st_q.line_pend;
      st_d.pend      = 1'b0;
    end
    if (wr_i) begin
      st_d.pix_live = wdata_i[3:0];
      if (wdata_i != 22'h000000) begin
        st_d.line_pend = wdata_i[21:4];
        st_d.pend      = 1'b1;
      end else begin
        // Zero write takes the whole offset at once
        st_d.line_live = 18'h00000;
        st_d.pend      = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign line_addr_o    = st_q.line_live;
  assign pixel_offset_o = st_q.pix_live;
  assign pending_o      = st_q.pend;

endmodule : frame_start_stage

`default_nettype wire

// ===== design/offset_regs_pkg.sv
package offset_regs_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned OFFS_W = 22;

  // Register byte addresses
  localparam logic [15:0] FB_START_ADDR  = 16'h8310;
  localparam logic [15:0] CB_START_ADDR  = 16'h8314;
  localparam logic [15:0] CUR_START_ADDR = 16'h8318;
  localparam logic [15:0] GAP_WORD_ADDR  = 16'h831C;
  localparam logic [15:0] VID_START_ADDR = 16'h8320;

  // Field layout
  localparam int unsigned FB_LINE_LSB  = 4;
  localparam int unsigned PIX_W        = 4;
  localparam int unsigned LINE_W       = 18;
  localparam int unsigned CB_ALIGN_W   = 4;
  localparam int unsigned CUR_ALIGN_W  = 2;
  localparam int unsigned VID_ALIGN_W  = 4;

  // Aperture limit: 4 MB
  localparam logic [22:0] APERTURE_BYTES = 23'h400000;

  // Values after reset
  localparam logic [21:0] OFFS_RESET = 22'h000000;
  localparam logic [31:0] GAP_WORD_VALUE = 32'h00000000;

endpackage : offset_regs_pkg

// ===== dv/offset_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module offset_regs_monitor (
  // Clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  // Register port
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  // Display engine side
  input wire logic [31:0] graphics_base_address_i,
  input wire logic        frame_start_i,
  input wire logic [31:0] frame_buffer_addr_o,
  input wire logic [3:0]  pixel_offset_o,
  input wire logic        frame_update_pending_o,
  input wire logic [31:0] compressed_buffer_addr_o,
  input wire logic [31:0] cursor_pattern_addr_o,
  input wire logic [31:0] video_buffer_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire fb_wr = wr_i && addr_i == 16'h8310;
  wire pend = frame_update_pending_o;
  property p_pix; fb_wr && wdata_i != '0 |=> pixel_offset_o == $past(wdata_i[3:0]); endproperty
  a_pix: assert property (p_pix) else $error("pix");
  property p_pend; fb_wr && wdata_i[21:4] != '0 |=> pend; endproperty
  a_pend: assert property (p_pend) else $error("pend");
  property p_hold; pend && !frame_start_i && !wr_i |=> $stable(frame_buffer_addr_o[21:4]); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_apply; pend && frame_start_i && !wr_i |=> !pend; endproperty
  a_apply: assert property (p_apply) else $error("apply");
  property p_cb; compressed_buffer_addr_o[3:0] == '0; endproperty
  a_cb: assert property (p_cb) else $error("cb");
  property p_cur; cursor_pattern_addr_o[1:0] == '0; endproperty
  a_cur: assert property (p_cur) else $error("cur");
  property p_vid; video_buffer_addr_o[3:0] == '0; endproperty
  a_vid: assert property (p_vid) else $error("vid");
  property p_gap; rd_i && addr_i == 16'h831C |=> rdata_o == '0; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_base; video_buffer_addr_o[31:22] == graphics_base_address_i[31:22]; endproperty
  a_base: assert property (p_base) else $error("base");
  c_fb: cover property (fb_wr);
  c_apply: cover property (pend && frame_start_i);
  c_gap: cover property (rd_i && addr_i == 16'h831C);
endmodule : offset_regs_monitor
bind display_buffer_offset_registers offset_regs_monitor u_mon (.*);
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk_i, rst_i, wr_i, rd_i, fs;
  logic [15:0] addr_i;
  logic [31:0] wdata_i, base, rdata_o, fb_o, cb_o, cur_o, vid_o;
  logic [3:0]  pix_o;
  logic        pend_o;
  int          failures, comparisons;
  display_buffer_offset_registers DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .graphics_base_address_i(base), .frame_start_i(fs), .frame_buffer_addr_o(fb_o),
    .pixel_offset_o(pix_o), .frame_update_pending_o(pend_o),
    .compressed_buffer_addr_o(cb_o), .cursor_pattern_addr_o(cur_o),
    .video_buffer_addr_o(vid_o));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask : rd
  task automatic s_regs;
    wr(16'h8314, 32'hFFFFFFFF); // single write, no later size change
    chk(cb_o, {base[31:22], 22'h3FFFF0});
    wr(16'h8318, 32'hFFFFFFFF);
    chk(cur_o, {base[31:22], 22'h3FFFFC});
    wr(16'h8320, 32'hFFFFFFFF);
    wr(16'h831C, 32'hFFFFFFFF);
    wr(16'h8400, 32'hFFFFFFFF);
    rd(16'h8314, 32'h003FFFF0);
    rd(16'h8318, 32'h003FFFFC);
    rd(16'h8320, 32'h003FFFF0);
    rd(16'h831C, 32'h00000000);
    rd(16'h8400, 32'h00000000);
    @(posedge core_clk_i);
    base <= 32'h7FC00000;
    #1;
    chk(vid_o, 32'h7FFFFFF0);
  endtask : s_regs
  task automatic s_frame;
    wr(16'h8310, 32'h00123456);
    chk({pix_o, pend_o, fb_o[21:4]}, {4'h6, 1'b1, 18'h00000});
    repeat (2) @(posedge core_clk_i);
    fs <= 1'b1;
    @(posedge core_clk_i);
    fs <= 1'b0;
    #1;
    chk({31'h00000000, pend_o}, 32'h00000000);
    chk(fb_o, {base[31:22], 22'h123456});
    rd(16'h8310, 32'h00123456);
    wr(16'h8310, 32'h00000010);
    chk({31'h00000000, pend_o}, 32'h00000001);
    wr(16'h8310, 32'h00000000);
    chk(fb_o, {base[31:22], 22'h000000});
    chk({31'h00000000, pend_o}, 32'h00000000);
  endtask : s_frame
  task automatic s_reset;
    wr(16'h8310, 32'h00000025);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    chk({pix_o, pend_o}, 32'h00000000);
    chk(fb_o, {base[31:22], 22'h000000});
    chk(cb_o, {base[31:22], 22'h000000});
    chk(cur_o, {base[31:22], 22'h000000});
    chk(vid_o, {base[31:22], 22'h000000});
    rd(16'h8320, 32'h00000000);
    wr(16'h8318, 32'h00000104);
    rd(16'h8318, 32'h00000104);
    @(posedge core_clk_i);
    #1;
    chk(rdata_o, 32'h00000000);
  endtask : s_reset
  task automatic results;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    #100000;
    failures++;
    results();
  end
  initial begin
    {rst_i, wr_i, rd_i, fs, addr_i, wdata_i} = {1'b1, 51'h0};
    base = 32'hA5C00000;
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    s_regs();
    s_frame();
    s_reset();
    results();
  end
endmodule : testbench
`default_nettype wire
